// [src/sarx_pkg.sv]
package sarx_pkg;
    // register indexes on the plain port
    localparam logic [3:0]  REG_CTRL_IDX   = 4'h0;
    localparam logic [3:0]  REG_STAT_IDX   = 4'h1;
    localparam logic [23:0] CTRL_RESET     = 24'h00_0000;
    // control field positions
    localparam int PM_LSB      = 0;
    localparam int PM_W        = 8;
    localparam int PSR_BIT     = 8;
    localparam int DC_LSB      = 9;
    localparam int DC_W        = 5;
    localparam int FP_LSB      = 14;
    localparam int FP_W        = 4;
    localparam int CKP_BIT     = 18;
    localparam int FSP_BIT     = 19;
    localparam int HCKP_BIT    = 20;
    localparam int CKD_BIT     = 21;
    localparam int FSD_BIT     = 22;
    localparam int HCKD_BIT    = 23;
    // fixed prescaler stage
    localparam logic [2:0]  DIV8_LAST      = 3'h7;
    // pin slots in the synchroniser vector
    localparam int PIN_BCK     = 0;
    localparam int PIN_FS      = 1;
    localparam int PIN_HF      = 2;
endpackage

// [src/sarx_clkgen.sv]
// The register offsets and the plain strobed port were decided locally.
`timescale 1ns/1ps
// Contract
// - hardware and software reset clear the whole clock control register.
// - prescale modulus field divides by value plus one, 1 to 256.
// - generated bit clock drives the pin and clocks the shift registers.
// - range bit set bypasses fixed divide-by-eight, cleared inserts it.
// - internal bit clock never faster than a quarter of oscillator.
// - frame divider gives words per frame minus one in network mode.
// - network mode with divider zero selects on-demand, no frame sync.
// - normal mode divider sets word rate; zero means every word framed.
// - high-frequency divider divides by field plus one, 1 to 16.
// - bit clock polarity picks launch and frame sync capture edges.
// - frame sync polarity bit selects active high or active low.
// - high-frequency polarity picks edges like the bit clock polarity.
// - async bit clock direction set drives pin, cleared takes pin input.
// - sync mode bit clock pin is output or input flag zero.
// - async frame sync direction set drives pin, cleared takes pin.
// - sync frame sync pin is flag one or buffer enable, or input flag.
// - async high-frequency direction set drives pin, cleared takes pin.
// - sync high-frequency pin is output or input flag two.
// - frame sync length bit picks word-long or one-bit-long sync.
module sarx_clkgen
    import sarx_pkg::*;
#(
    parameter int SLOT_W = 5
)(
    // clock and reset
    input  wire logic              mclk,
    input  wire logic              reset_n,
    input  wire logic              clk_en,
    input  wire logic              sw_reset,
    // register port
    input  wire logic [3:0]        reg_addr,
    input  wire logic [23:0]       reg_wdata,
    input  wire logic              reg_wr,
    input  wire logic              reg_rd,
    output logic      [23:0]       reg_rdata,
    // mode inputs from the rest of the port
    input  wire logic              synchronous_mode_select,
    input  wire logic              tx_buffer_enable_select,
    input  wire logic              network_mode,
    input  wire logic              frame_sync_length,
    input  wire logic [SLOT_W-1:0] slot_bits_m1,
    input  wire logic              output_flag_zero,
    input  wire logic              output_flag_one,
    input  wire logic              output_flag_two,
    input  wire logic              tx_buffer_enable,
    // bit clock pin
    input  wire logic              rx_bit_clock_pin_in,
    output logic                   rx_bit_clock_pin_out,
    output logic                   rx_bit_clock_pin_oe,
    // frame sync pin
    input  wire logic              rx_frame_sync_pin_in,
    output logic                   rx_frame_sync_pin_out,
    output logic                   rx_frame_sync_pin_oe,
    // high-frequency clock pin
    input  wire logic              rx_hf_clock_pin_in,
    output logic                   rx_hf_clock_pin_out,
    output logic                   rx_hf_clock_pin_oe,
    // toward the receive shift registers
    output logic                   rx_shift_clk,
    output logic                   rx_launch,
    output logic                   rx_capture,
    output logic                   rx_frame_start,
    output logic                   input_flag_zero,
    output logic                   input_flag_one,
    output logic                   input_flag_two
);

    logic [23:0]       ctrl_r;
    logic [2:0]        sync1_r;
    logic [2:0]        sync2_r;
    logic              hf_prev_r;
    logic              bck_prev_r;
    logic [2:0]        div8_r;
    logic [7:0]        pre_r;
    logic              hf_int_r;
    logic [3:0]        hfd_r;
    logic              bit_tick_r;
    logic              bck_int_r;
    logic [SLOT_W-1:0] bit_r;
    logic [4:0]        word_r;
    logic              fs_act_r;
    logic              fs_seen_r;

    // a count left above a newly written limit wraps at the next step
    // instead of running round its whole range first
    function automatic logic at_limit(input logic [7:0] count,
                                      input logic [7:0] limit);
        return count >= limit;
    endfunction

    // edge of a sampled level, falling when fall_sel is high
    function automatic logic edge_of(input logic prev,
                                     input logic level,
                                     input logic fall_sel);
        return fall_sel ? (prev & ~level) : (~prev & level);
    endfunction

    // control fields
    wire [7:0] prescale_modulus        = ctrl_r[PM_LSB +: PM_W];
    wire       rx_prescaler_range      = ctrl_r[PSR_BIT];
    wire [4:0] rx_frame_rate_divider   = ctrl_r[DC_LSB +: DC_W];
    wire [3:0] rx_hf_clock_divider     = ctrl_r[FP_LSB +: FP_W];
    wire       rx_bit_clock_polarity   = ctrl_r[CKP_BIT];
    wire       rx_frame_sync_polarity  = ctrl_r[FSP_BIT];
    wire       rx_hf_clock_polarity    = ctrl_r[HCKP_BIT];
    wire       rx_bit_clock_direction  = ctrl_r[CKD_BIT];
    wire       rx_frame_sync_direction = ctrl_r[FSD_BIT];
    wire       rx_hf_clock_direction   = ctrl_r[HCKD_BIT];
    wire       sync_mode               = synchronous_mode_select;

    // register decode
    wire sel_ctrl = (reg_addr == REG_CTRL_IDX);
    wire sel_stat = (reg_addr == REG_STAT_IDX);
    wire [23:0] stat_word = {11'h000, word_r, fs_act_r, bck_int_r,
                             hf_int_r, sync2_r, 2'b00};
    wire [23:0] rdata_nxt = !reg_rd   ? 24'h00_0000 :
                            sel_ctrl  ? ctrl_r :
                            sel_stat  ? stat_word : 24'h00_0000;

    // synchronised pin levels
    wire bck_pin = sync2_r[PIN_BCK];
    wire fs_pin  = sync2_r[PIN_FS];
    wire hf_pin  = sync2_r[PIN_HF];

    wire tick8 = rx_prescaler_range | (div8_r == DIV8_LAST);
    // prescaler wraps at modulus, ratio modulus plus one
    wire pre_tick = tick8 && at_limit(pre_r, prescale_modulus);

    // external hf source only when async mode leaves the pin as input
    wire hf_ext = !sync_mode && !rx_hf_clock_direction;
    // hf polarity picks the counted external edge
    wire hf_edge = edge_of(hf_prev_r, hf_pin, rx_hf_clock_polarity);
    // hf clock tapped before the final divider
    wire hf_src_tick = hf_ext ? hf_edge : pre_tick;
    // high-frequency divider, ratio field plus one
    wire hfd_wrap = hf_src_tick &&
                    at_limit(8'(hfd_r), 8'(rx_hf_clock_divider));
    // no two ticks in a row, half period at least two cycles
    wire bit_tick_nxt = hfd_wrap && !bit_tick_r;

    // async direction cleared takes bit clock from the pin
    wire bck_ext = !sync_mode && !rx_bit_clock_direction;
    // one bit clock for pin and shift registers
    wire bck_use = bck_ext ? bck_pin : bck_int_r;
    // polarity swaps launch and capture edges
    wire launch  = edge_of(bck_prev_r, bck_use, rx_bit_clock_polarity);
    wire capture = edge_of(bck_prev_r, bck_use, !rx_bit_clock_polarity);

    // word and frame counters, advanced on the launch edge
    wire bit_last  = at_limit(8'(bit_r), 8'(slot_bits_m1));
    wire word_last = at_limit(8'(word_r), 8'(rx_frame_rate_divider));
    wire [SLOT_W-1:0] bit_nxt =
        bit_last ? '0 : SLOT_W'(bit_r + 1'b1);
    // frame divider counts words per frame minus one
    // divider zero wraps every word, continuous framing
    wire [4:0] word_nxt = !bit_last ? word_r :
                          word_last ? 5'h00 : 5'(word_r + 1'b1);
    // network mode with divider zero is on-demand
    wire on_demand = network_mode && (rx_frame_rate_divider == 5'h00);
    // one-bit sync or whole first word
    wire fs_act_nxt = !on_demand && (word_nxt == 5'h00) &&
                      (!frame_sync_length || bit_nxt == '0);

    // internal or external frame sync source
    wire fs_int = !sync_mode && rx_frame_sync_direction;
    // polarity bit maps active level to the pin
    wire fs_level = fs_int ? fs_act_r
                           : (fs_pin ^ rx_frame_sync_polarity);
    // frame sync sampled on the capture edge
    wire frame_start_nxt = capture && fs_level && !fs_seen_r;

    // pin drive, async and sync mode
    // bit clock driven when direction set
    // sync mode bit clock pin carries flag zero
    wire bck_oe_nxt  = rx_bit_clock_direction;
    wire bck_out_nxt = sync_mode ? output_flag_zero : bck_int_r;
    // sync frame pin, flag one or buffer enable
    wire fs_oe_nxt   = rx_frame_sync_direction;
    wire fs_out_nxt  = !sync_mode ? (fs_act_r ^ rx_frame_sync_polarity) :
                       tx_buffer_enable_select ? tx_buffer_enable :
                       output_flag_one;
    // hf clock driven when direction set
    // sync mode hf pin carries flag two
    wire hf_oe_nxt   = rx_hf_clock_direction;
    wire hf_out_nxt  = sync_mode ? output_flag_two
                                 : (hf_int_r ^ rx_hf_clock_polarity);
    // sync mode with direction cleared reads the pin as an input flag
    wire iflag1_nxt = (sync_mode && !rx_frame_sync_direction) ? fs_pin
                                                              : 1'b0;
    wire iflag0_nxt = (sync_mode && !rx_bit_clock_direction) ? bck_pin
                                                             : 1'b0;
    wire iflag2_nxt = (sync_mode && !rx_hf_clock_direction) ? hf_pin
                                                            : 1'b0;

    // control register
    always_ff @(posedge mclk)
    begin
        if (!reset_n)
            ctrl_r <= CTRL_RESET;
        else if (clk_en && sw_reset)
            ctrl_r <= CTRL_RESET;
        else if (clk_en && reg_wr && sel_ctrl)
            ctrl_r <= reg_wdata;
    end

    always_ff @(posedge mclk)
    begin
        if (!reset_n)
            reg_rdata <= 24'h00_0000;
        else if (clk_en)
            reg_rdata <= rdata_nxt;
    end

    // pin synchronisers, first stage read only by the second
    always_ff @(posedge mclk)
    begin
        if (!reset_n)
        begin
            sync1_r <= 3'h0;
            sync2_r <= 3'h0;
        end
        else if (clk_en)
        begin
            sync1_r <= {rx_hf_clock_pin_in, rx_frame_sync_pin_in,
                        rx_bit_clock_pin_in};
            sync2_r <= sync1_r;
        end
    end

    // divider chain
    always_ff @(posedge mclk)
    begin
        if (!reset_n)
        begin
            div8_r     <= 3'h0;
            pre_r      <= 8'h00;
            hf_int_r   <= 1'b0;
            hfd_r      <= 4'h0;
            bit_tick_r <= 1'b0;
            bck_int_r  <= 1'b0;
            hf_prev_r  <= 1'b0;
        end
        else if (clk_en)
        begin
            div8_r    <= rx_prescaler_range ? 3'h0 : 3'(div8_r + 1'b1);
            hf_prev_r <= hf_pin;
            if (tick8)
                pre_r <= pre_tick ? 8'h00 : 8'(pre_r + 1'b1);
            if (pre_tick)
                hf_int_r <= ~hf_int_r;
            if (hf_src_tick)
                hfd_r <= hfd_wrap ? 4'h0 : 4'(hfd_r + 1'b1);
            bit_tick_r <= bit_tick_nxt;
            if (bit_tick_nxt)
                bck_int_r <= ~bck_int_r;
        end
    end

    // frame sync generator and capture
    always_ff @(posedge mclk)
    begin
        if (!reset_n)
        begin
            bck_prev_r <= 1'b0;
            bit_r      <= '0;
            word_r     <= 5'h00;
            fs_act_r   <= 1'b0;
            fs_seen_r  <= 1'b0;
        end
        else if (clk_en)
        begin
            bck_prev_r <= bck_use;
            if (launch)
            begin
                bit_r    <= bit_nxt;
                word_r   <= word_nxt;
                fs_act_r <= fs_act_nxt;
            end
            if (capture)
                fs_seen_r <= fs_level;
        end
    end

    // pin drivers, registered so no pin sees a decode glitch
    always_ff @(posedge mclk)
    begin
        if (!reset_n)
        begin
            rx_bit_clock_pin_out  <= 1'b0;
            rx_bit_clock_pin_oe   <= 1'b0;
            rx_frame_sync_pin_out <= 1'b0;
            rx_frame_sync_pin_oe  <= 1'b0;
            rx_hf_clock_pin_out   <= 1'b0;
            rx_hf_clock_pin_oe    <= 1'b0;
        end
        else if (clk_en)
        begin
            rx_bit_clock_pin_out  <= bck_out_nxt;
            rx_bit_clock_pin_oe   <= bck_oe_nxt;
            rx_frame_sync_pin_out <= fs_out_nxt;
            rx_frame_sync_pin_oe  <= fs_oe_nxt;
            rx_hf_clock_pin_out   <= hf_out_nxt;
            rx_hf_clock_pin_oe    <= hf_oe_nxt;
        end
    end

    // strobes toward the receive shift registers
    always_ff @(posedge mclk)
    begin
        if (!reset_n)
        begin
            rx_shift_clk          <= 1'b0;
            rx_launch             <= 1'b0;
            rx_capture            <= 1'b0;
            rx_frame_start        <= 1'b0;
        end
        else if (clk_en)
        begin
            rx_shift_clk          <= bck_use;
            rx_launch             <= launch;
            rx_capture            <= capture;
            rx_frame_start        <= frame_start_nxt;
        end
    end

    // input flags of synchronous mode
    always_ff @(posedge mclk)
    begin
        if (!reset_n)
        begin
            input_flag_zero       <= 1'b0;
            input_flag_one        <= 1'b0;
            input_flag_two        <= 1'b0;
        end
        else if (clk_en)
        begin
            input_flag_zero       <= iflag0_nxt;
            input_flag_one        <= iflag1_nxt;
            input_flag_two        <= iflag2_nxt;
        end
    end

endmodule // sarx_clkgen

// [bench/sarx_clkgen_monitor.sv]
`timescale 1ns/1ps
module sarx_clkgen_monitor
    import sarx_pkg::*;
(
    // clock, reset, register port
    input wire logic        mclk,
    input wire logic        reset_n,
    input wire logic        clk_en,
    input wire logic        sw_reset,
    input wire logic [3:0]  reg_addr,
    input wire logic [23:0] reg_wdata,
    input wire logic        reg_wr,
    input wire logic        reg_rd,
    input wire logic [23:0] reg_rdata,
    // modes, flags and pins
    input wire logic        synchronous_mode_select,
    input wire logic        tx_buffer_enable_select,
    input wire logic        output_flag_zero,
    input wire logic        tx_buffer_enable,
    input wire logic        input_flag_zero,
    input wire logic        input_flag_one,
    input wire logic        rx_bit_clock_pin_out,
    input wire logic        rx_bit_clock_pin_oe,
    input wire logic        rx_frame_sync_pin_out,
    input wire logic        rx_frame_sync_pin_oe,
    input wire logic        rx_hf_clock_pin_oe
);
    default clocking cb @(posedge mclk);
    endclocking
    default disable iff (!reset_n);
    wire ctl_wr = clk_en && reg_wr && !sw_reset && reg_addr == REG_CTRL_IDX;
    wire sync_mode = synchronous_mode_select;

    property p_sw_clear;
        clk_en && sw_reset ##1 clk_en && reg_rd && reg_addr == REG_CTRL_IDX
            |=> reg_rdata == CTRL_RESET;
    endproperty
    a_sw_clear: assert property (p_sw_clear)
        else $error("control register kept bits over software reset");
    property p_bck_dir;
        ctl_wr ##1 clk_en
            |=> rx_bit_clock_pin_oe == $past(reg_wdata[CKD_BIT], 2);
    endproperty
    a_bck_dir: assert property (p_bck_dir)
        else $error("bit clock pin enable does not follow its bit");
    property p_fs_dir;
        ctl_wr ##1 clk_en
            |=> rx_frame_sync_pin_oe == $past(reg_wdata[FSD_BIT], 2);
    endproperty
    a_fs_dir: assert property (p_fs_dir)
        else $error("frame sync pin enable does not follow its bit");
    property p_hf_dir;
        ctl_wr ##1 clk_en
            |=> rx_hf_clock_pin_oe == $past(reg_wdata[HCKD_BIT], 2);
    endproperty
    a_hf_dir: assert property (p_hf_dir)
        else $error("hf clock pin enable does not follow its bit");
    property p_flag0;
        clk_en && sync_mode
            |=> !rx_bit_clock_pin_oe
                || rx_bit_clock_pin_out == $past(output_flag_zero);
    endproperty
    a_flag0: assert property (p_flag0)
        else $error("bit clock pin does not show output flag zero");
    property p_buf_en;
        clk_en && sync_mode && tx_buffer_enable_select
            |=> !rx_frame_sync_pin_oe
                || rx_frame_sync_pin_out == $past(tx_buffer_enable);
    endproperty
    a_buf_en: assert property (p_buf_en)
        else $error("frame sync pin does not show buffer enable");
    property p_async_flags;
        clk_en && !sync_mode |=> !input_flag_zero && !input_flag_one;
    endproperty
    a_async_flags: assert property (p_async_flags)
        else $error("input flag raised outside synchronous mode");
    // two cycles per half period keeps the bit clock at or below a quarter
    property p_tick_gap;
        // leaving sync mode swaps the pin source a cycle late
        !sync_mode && !$past(sync_mode) && !$past(sync_mode, 2)
            && $changed(rx_bit_clock_pin_out)
            |=> $stable(rx_bit_clock_pin_out);
    endproperty
    a_tick_gap: assert property (p_tick_gap)
        else $error("bit clock half period shorter than two cycles");

    c_sync_pin: cover property (sync_mode && rx_frame_sync_pin_oe);
    c_sw_reset: cover property (sw_reset ##1 reg_rd);
    c_bck_edge: cover property ($changed(rx_bit_clock_pin_out));
endmodule // sarx_clkgen_monitor

bind sarx_clkgen sarx_clkgen_monitor sarx_clkgen_monitor_inst (.mclk,
    .reset_n, .clk_en, .sw_reset, .reg_addr, .reg_wdata, .reg_wr, .reg_rd,
    .reg_rdata, .synchronous_mode_select, .tx_buffer_enable_select,
    .output_flag_zero, .tx_buffer_enable, .input_flag_zero, .input_flag_one,
    .rx_bit_clock_pin_out, .rx_bit_clock_pin_oe, .rx_frame_sync_pin_out,
    .rx_frame_sync_pin_oe, .rx_hf_clock_pin_oe);

// [bench/sarx_codec_model.sv]
`timescale 1ns/1ps
module sarx_codec_model (
    // clock and traffic control
    input  wire logic mclk,
    input  wire logic ext_run,
    // device side of the pins
    input  wire logic rx_bit_clock_pin_out,
    input  wire logic rx_bit_clock_pin_oe,
    input  wire logic rx_frame_sync_pin_out,
    input  wire logic rx_frame_sync_pin_oe,
    input  wire logic rx_hf_clock_pin_out,
    input  wire logic rx_hf_clock_pin_oe,
    // resolved pin levels
    output logic      rx_bit_clock_pin_in,
    output logic      rx_frame_sync_pin_in,
    output logic      rx_hf_clock_pin_in
);
    logic [1:0] ph_r = 2'h0;
    logic [2:0] bit_r = 3'h0;
    logic       bck_r = 1'b0;
    logic       hf_r = 1'b0;
    // codec clocks stand still outside traffic; bit clock half period 3 cycles, hf clock 1
    always @(posedge mclk)
    begin
        ph_r <= (ext_run && ph_r != 2'h2) ? ph_r + 2'h1 : 2'h0;
        hf_r <= ext_run && !hf_r;
        bck_r <= ext_run && (bck_r ^ (ph_r == 2'h2));
        if (ext_run && ph_r == 2'h2 && bck_r)
            bit_r <= bit_r + 3'h1;
    end
    // codec only drives a pin the device leaves as input
    assign rx_bit_clock_pin_in = rx_bit_clock_pin_oe ? rx_bit_clock_pin_out
                                                     : bck_r;
    assign rx_hf_clock_pin_in = rx_hf_clock_pin_oe ? rx_hf_clock_pin_out
                                                   : hf_r;
    // frame start shown active high, one bit in eight
    assign rx_frame_sync_pin_in = rx_frame_sync_pin_oe ? rx_frame_sync_pin_out
                                  : (!ext_run || bit_r == 3'h0);
endmodule // sarx_codec_model

// [bench/testbench.sv]
`timescale 1ns/1ps
`define CHK(nm, e, g) begin n_compared++; if ((g) !== (e)) begin \
    failures++; $display("BAD %s exp %0h got %0h", nm, e, g); end end
module testbench;
    import sarx_pkg::*;
    logic mclk = 1'b0, reset_n = 1'b0, clk_en = 1'b1, sw_reset = 1'b0;
    logic reg_wr = 1'b0, reg_rd = 1'b0, ext_run = 1'b0;
    logic [3:0] reg_addr = 4'h0;
    logic [23:0] reg_wdata = 24'h00_0000, reg_rdata;
    logic synchronous_mode_select = 1'b0, tx_buffer_enable_select = 1'b0;
    logic network_mode = 1'b0, frame_sync_length = 1'b0;
    logic [4:0] slot_bits_m1 = 5'h03;
    logic output_flag_zero = 1'b0, output_flag_one = 1'b0;
    logic output_flag_two = 1'b0, tx_buffer_enable = 1'b0;
    logic rx_bit_clock_pin_in, rx_bit_clock_pin_out, rx_bit_clock_pin_oe;
    logic rx_frame_sync_pin_in, rx_frame_sync_pin_out, rx_frame_sync_pin_oe;
    logic rx_hf_clock_pin_in, rx_hf_clock_pin_out, rx_hf_clock_pin_oe;
    logic rx_shift_clk, rx_launch, rx_capture, rx_frame_start;
    logic input_flag_zero, input_flag_one, input_flag_two;
    int failures = 0, n_compared = 0;
    wire [2:0] oes = {rx_bit_clock_pin_oe, rx_frame_sync_pin_oe,
                      rx_hf_clock_pin_oe};
    wire [2:0] outs = {rx_bit_clock_pin_out, rx_frame_sync_pin_out,
                       rx_hf_clock_pin_out};
    wire [2:0] ins = {input_flag_zero, input_flag_one, input_flag_two};

    sarx_clkgen sarx_clkgen_inst (.mclk, .reset_n, .clk_en, .sw_reset,
        .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
        .synchronous_mode_select, .tx_buffer_enable_select, .network_mode,
        .frame_sync_length, .slot_bits_m1, .output_flag_zero,
        .output_flag_one, .output_flag_two, .tx_buffer_enable,
        .rx_bit_clock_pin_in, .rx_bit_clock_pin_out, .rx_bit_clock_pin_oe,
        .rx_frame_sync_pin_in, .rx_frame_sync_pin_out, .rx_frame_sync_pin_oe,
        .rx_hf_clock_pin_in, .rx_hf_clock_pin_out, .rx_hf_clock_pin_oe,
        .rx_shift_clk, .rx_launch, .rx_capture, .rx_frame_start,
        .input_flag_zero, .input_flag_one, .input_flag_two);
    sarx_codec_model sarx_codec_model_inst (.mclk, .ext_run,
        .rx_bit_clock_pin_out, .rx_bit_clock_pin_oe, .rx_frame_sync_pin_out,
        .rx_frame_sync_pin_oe, .rx_hf_clock_pin_out, .rx_hf_clock_pin_oe,
        .rx_bit_clock_pin_in, .rx_frame_sync_pin_in, .rx_hf_clock_pin_in);

    initial
    begin
        forever #50 mclk = ~mclk;
    end
    task automatic stop_test;
        $display("compared %0d failures %0d", n_compared, failures);
        if (failures == 0 && n_compared > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask
    // bus tasks start just after a rising edge and return on one
    task automatic wr(input logic [23:0] d, input logic sr = 1'b0);
        reg_addr <= REG_CTRL_IDX;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        sw_reset <= sr;
        @(posedge mclk);
        reg_wr <= 1'b0;
        sw_reset <= 1'b0;
    endtask
    task automatic rd(input logic [3:0] a, input logic [23:0] e);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge mclk);
        reg_rd <= 1'b0;
        @(negedge mclk);
        `CHK("read data", e, reg_rdata)
        @(posedge mclk);
    endtask
    function automatic logic pick(input int s);
        return s == 0 ? rx_bit_clock_pin_out :
               s == 1 ? rx_hf_clock_pin_out : rx_shift_clk;
    endfunction
    // cycles between two rising edges, bounded
    task automatic per(input int s, input int e);
        int n = 0, k = 0, g = 0;
        logic p = pick(s);
        while (k < 2 && g < 3000)
        begin
            @(negedge mclk);
            g++;
            if (k == 1) n++;
            if (pick(s) && !p) k++;
            p = pick(s);
        end
        `CHK("period", e, n)
        @(posedge mclk);
    endtask
    task automatic t_regs;
        rd(REG_CTRL_IDX, CTRL_RESET);
        `CHK("pin enables", 3'h0, oes)
        wr(24'hE5_A5A5);
        rd(REG_CTRL_IDX, 24'hE5_A5A5);
        `CHK("pin enables", 3'h7, oes)
        rd(4'hF, 24'h00_0000);
        wr(24'h12_3456, 1'b1);
        rd(REG_CTRL_IDX, CTRL_RESET);
        // clock enable low must hold the register
        clk_en <= 1'b0;
        wr(24'h00_00FF);
        clk_en <= 1'b1;
        rd(REG_CTRL_IDX, CTRL_RESET);
    endtask
    task automatic t_clk(input logic psr, input logic [7:0] pm,
                         input logic [3:0] fp);
        int t = (psr ? 1 : 8) * (pm + 1) * (fp + 1);
        wr({6'b101_100, fp, 5'h00, psr, pm});
        repeat (8) @(posedge mclk);
        per(0, 2 * t);
        per(1, 2 * t / (fp + 1));
        per(2, 2 * t);
    endtask
    task automatic t_frm(input logic nt, ln, fsp, input logic [4:0] dc,
                         input int e_act, e_st);
        int act = 0, st = 0;
        network_mode <= nt;
        frame_sync_length <= ln;
        wr({3'b111, 1'b0, fsp, 1'b0, 4'h0, dc, 1'b1, 8'h01});
        repeat (64) @(posedge mclk);
        repeat (480)
        begin
            @(negedge mclk);
            act += (rx_frame_sync_pin_out === !fsp);
            st += (rx_frame_start === 1'b1);
        end
        `CHK("frame sync active", e_act, act)
        `CHK("frame starts", e_st, st)
        @(posedge mclk);
    endtask
    task automatic t_sync;
        synchronous_mode_select <= 1'b1;
        output_flag_zero <= 1'b1;
        output_flag_one <= 1'b1;
        wr(24'hE0_0000);
        repeat (3) @(negedge mclk);
        `CHK("output flags", 3'h6, outs)
        @(posedge mclk);
        tx_buffer_enable_select <= 1'b1;
        output_flag_one <= 1'b0;
        tx_buffer_enable <= 1'b1;
        repeat (3) @(negedge mclk);
        `CHK("buffer enable", 3'h6, outs)
        @(posedge mclk);
        tx_buffer_enable_select <= 1'b0;
        wr(24'h00_0000);
        repeat (8) @(negedge mclk);
        `CHK("input flags", 3'h2, ins)
        @(posedge mclk);
        synchronous_mode_select <= 1'b0;
        repeat (3) @(negedge mclk);
        `CHK("async flags", 3'h0, ins)
        @(posedge mclk);
    endtask
    task automatic t_ext;
        ext_run <= 1'b1;
        wr(24'h00_0000);
        repeat (20) @(posedge mclk);
        per(2, 6);
        ext_run <= 1'b0;
    endtask

    initial
    begin
        repeat (6) @(posedge mclk);
        reset_n <= 1'b1;
        @(posedge mclk);
        t_regs();
        // bypass never paired with modulus zero
        t_clk(1'b1, 8'h01, 4'h0);
        t_clk(1'b1, 8'h02, 4'h1);
        t_clk(1'b0, 8'h00, 4'h0);
        t_clk(1'b1, 8'hFF, 4'h0);
        t_clk(1'b1, 8'h01, 4'hF);
        t_frm(1'b1, 1'b1, 1'b0, 5'h00, 0, 0);
        t_frm(1'b0, 1'b1, 1'b0, 5'h00, 120, 30);
        t_frm(1'b1, 1'b1, 1'b0, 5'h02, 40, 10);
        t_frm(1'b1, 1'b0, 1'b0, 5'h02, 160, 10);
        t_frm(1'b0, 1'b1, 1'b1, 5'h02, 40, 10);
        t_sync();
        t_ext();
        stop_test();
    end
    // run needs under 10000 cycles
    initial
    begin
        #5_000_000;
        failures++;
        stop_test();
    end
endmodule // testbench
